// *** core/alarm_mute_and_dac_bias_regs.sv ***
// Alarm masking, DAC mute control, fuse status and DAC bias register bank
//
// Operation
// R1: Mask bit 7 hides the link-loss alarm from the combined alarm output.
// R2: Mask bit 6 hides the link-timeout alarm from the combined alarm output.
// R3: Mask bit 5 hides the lane CRC alarm from the combined alarm output.
// R4: Mask bit 0 hides the reference misalignment alarm from the alarm output.
// R5: CRC alarm mutes DACs unless mute-mask bit 5 set; bit resets to 1.
// R6: Misalignment alarm mutes DACs unless mute-mask bit 0 set; resets to 1.
// R7: Link-loss mute holds until alarm cleared, or auto-unmutes on recovery if bit 7.
// R8: CRC recovery bit matters only while CRC muting is enabled.
// R9: CRC recovery 0 waits for alarm clear; 1 unmutes when live fault drops.
// R10: Status bit 0 reads 1 only once fuse load finished, else 0.
// R11: Fuse auto-load completes in fewer than 523,000 clocks after reset.
// R12: Host touches no fuse-backed register before fuse-done reads 1.
// R13: Six-bit fine bias for channel A in bits 5-0, trimmed reset value.
// R14: Six-bit fine bias for channel B in bits 5-0; bits 7-6 read zero.
// R15: Four-bit coarse bias for channel A in bits 3-0, resets to ones.
// R16: Four-bit coarse bias for channel B in bits 3-0, resets to ones.
// R17: Coarse registers hold a sleep coarse value in bits 7-4 per channel.
// R18: Link-loss alarm sets on link-up falling while link enabled; write 1 clears.
// R19: Link-timeout alarm sets when enabled link stays down beyond the timer.
// R20: Combined alarm output is OR of unmasked alarm status bits.
`timescale 1ns/1ps
`default_nettype none
module alarm_mute_and_dac_bias_regs #(
	parameter int FUSE_CYCLES = alarm_bias_pkg::FUSE_LOAD_CYCLES,
	parameter logic [5:0] FINE_TRIM_A = alarm_bias_pkg::RST_FINE_BIAS,
	parameter logic [5:0] FINE_TRIM_B = alarm_bias_pkg::RST_FINE_BIAS
) (
	input  wire logic                                     clock_i,
	input  wire logic                                     arst_n_i,
	input  wire logic                                     reg_wr_i,
	input  wire logic                                     reg_rd_i,
	input  wire logic [11:0]                              reg_addr_i,
	input  wire logic [7:0]                               reg_wdata_i,
	output logic      [7:0]                               reg_rdata_o,
	input  wire logic                                     serial_link_enable_i,
	input  wire logic                                     link_up_i,
	input  wire logic [alarm_bias_pkg::LINK_TIMER_W-1:0]  link_down_timer_i,
	input  wire logic                                     crc_fault_i,
	input  wire logic                                     ref_misalign_i,
	input  wire logic                                     alarm_clear_i,
	input  wire logic [7:0]                               alarm_clear_bits_i,
	input  wire logic                                     sleep_a_i,
	input  wire logic                                     sleep_b_i,
	output logic      [7:0]                               alarm_status_o,
	output logic                                          alarm_o,
	output logic                                          dac_mute_o,
	output logic                                          fuse_done_o,
	output logic      [5:0]                               fine_bias_a_o,
	output logic      [5:0]                               fine_bias_b_o,
	output logic      [3:0]                               coarse_bias_a_o,
	output logic      [3:0]                               coarse_bias_b_o
);
	import alarm_bias_pkg::*;

	typedef enum logic [1:0] {
		FUSE_LOADING = 2'b01,
		FUSE_IDLE    = 2'b10
	} fuse_state_t;

	logic [7:0]  out_mask_q;
	logic [7:0]  mute_src_q;
	logic [7:0]  recovery_q;
	logic [5:0]  fine_a_q;
	logic [5:0]  fine_b_q;
	logic [7:0]  coarse_a_q;
	logic [7:0]  coarse_b_q;
	logic [7:0]  alarm_q;
	logic        link_up_q;
	logic [LINK_TIMER_W-1:0] down_cnt_q;
	logic        link_mute_q;
	logic        crc_mute_q;
	fuse_state_t fuse_state_q;
	logic [19:0] fuse_cnt_q;
	logic [7:0]  alarm_set;
	logic [7:0]  clear_bits;
	logic        timer_hit;

	// Register write strobe for one address
	function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Fuse auto-load sequencer; load length is bounded below the limit
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fuse_state_q <= FUSE_LOADING;
			fuse_cnt_q   <= 20'h00000;
		end else begin
			case (fuse_state_q)
				FUSE_LOADING: begin
					fuse_cnt_q <= fuse_cnt_q + 20'h00001;
					if (fuse_cnt_q == 20'(FUSE_CYCLES - 1)) begin
						fuse_state_q <= FUSE_IDLE; // R11
					end
				end
				FUSE_IDLE: fuse_state_q <= FUSE_IDLE;
				default:   fuse_state_q <= FUSE_LOADING;
			endcase
		end
	end

	// Done flag follows the sequencer idle state
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fuse_done_o <= 1'b0;
		end else begin
			fuse_done_o <= (fuse_state_q == FUSE_IDLE); // R10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers; fine trims load while fuses stream, so writes are dropped until loading ends
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_mask_q  <= RST_ALARM_OUTPUT_MASK;
			mute_src_q  <= RST_DAC_MUTE_SRC_MASK; // R5 R6
			recovery_q  <= RST_DAC_MUTE_RECOVERY; // R7
			fine_a_q    <= 6'h00;
			fine_b_q    <= 6'h00;
			coarse_a_q  <= RST_COARSE_BIAS; // R15
			coarse_b_q  <= RST_COARSE_BIAS; // R16
		end else if (fuse_state_q == FUSE_LOADING) begin
			fine_a_q <= FINE_TRIM_A; // R13
			fine_b_q <= FINE_TRIM_B; // R14
		end else if (reg_wr_i) begin
			// Fuse-backed writes are only honoured once loading is over
			if (wr_hit(reg_addr_i, OFS_ALARM_OUTPUT_MASK))  out_mask_q  <= reg_wdata_i;
			if (wr_hit(reg_addr_i, OFS_DAC_MUTE_SRC_MASK))  mute_src_q  <= reg_wdata_i;
			if (wr_hit(reg_addr_i, OFS_DAC_MUTE_RECOVERY))  recovery_q  <= reg_wdata_i;
			if (wr_hit(reg_addr_i, OFS_FINE_BIAS_CHAN_A))   fine_a_q    <= reg_wdata_i[5:0]; // R13
			if (wr_hit(reg_addr_i, OFS_FINE_BIAS_CHAN_B))   fine_b_q    <= reg_wdata_i[5:0]; // R14
			if (wr_hit(reg_addr_i, OFS_COARSE_BIAS_CHAN_A)) coarse_a_q  <= reg_wdata_i; // R17
			if (wr_hit(reg_addr_i, OFS_COARSE_BIAS_CHAN_B)) coarse_b_q  <= reg_wdata_i; // R17
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link-down timer; counts only while enabled link is down
	assign timer_hit = serial_link_enable_i && !link_up_i && (down_cnt_q >= link_down_timer_i);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			link_up_q  <= 1'b0;
			down_cnt_q <= '0;
		end else begin
			link_up_q <= link_up_i;
			if (!serial_link_enable_i || link_up_i) begin
				down_cnt_q <= '0;
			end else if (!timer_hit) begin
				down_cnt_q <= down_cnt_q + 1'b1;
			end
		end
	end

	// Alarm event sources
	always_comb begin
		alarm_set = 8'h00;
		alarm_set[BIT_LINK_LOSS]    = serial_link_enable_i && link_up_q && !link_up_i; // R18
		alarm_set[BIT_LINK_TIMEOUT] = timer_hit; // R19
		alarm_set[BIT_LANE_CRC]     = crc_fault_i;
		alarm_set[BIT_REF_MISALIGN] = ref_misalign_i;
		clear_bits = alarm_clear_i ? alarm_clear_bits_i : 8'h00;
	end

	// Sticky alarms: a set in the clearing cycle wins
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			alarm_q <= 8'h00;
		end else begin
			alarm_q <= (alarm_q & ~clear_bits) | alarm_set; // R18
		end
	end

	// Combined alarm output from unmasked status bits
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			alarm_o        <= 1'b0;
			alarm_status_o <= 8'h00;
		end else begin
			alarm_status_o <= alarm_q;
			alarm_o <= (alarm_q[BIT_LINK_LOSS]    && !out_mask_q[BIT_LINK_LOSS])    // R1 R20
			        || (alarm_q[BIT_LINK_TIMEOUT] && !out_mask_q[BIT_LINK_TIMEOUT]) // R2
			        || (alarm_q[BIT_LANE_CRC]     && !out_mask_q[BIT_LANE_CRC])     // R3
			        || (alarm_q[BIT_REF_MISALIGN] && !out_mask_q[BIT_REF_MISALIGN]); // R4
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mute holders: link loss always mutes; CRC muting only when enabled
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			link_mute_q <= 1'b0;
			crc_mute_q  <= 1'b0;
		end else begin
			if (alarm_set[BIT_LINK_LOSS]) begin
				link_mute_q <= 1'b1;
			end else if (recovery_q[BIT_LINK_LOSS]) begin
				link_mute_q <= link_mute_q && !link_up_i; // R7
			end else begin
				link_mute_q <= link_mute_q && alarm_q[BIT_LINK_LOSS]; // R7
			end
			if (mute_src_q[BIT_LANE_CRC]) begin
				crc_mute_q <= 1'b0; // R8
			end else if (crc_fault_i) begin
				crc_mute_q <= 1'b1; // R5
			end else if (recovery_q[BIT_LANE_CRC]) begin
				crc_mute_q <= 1'b0; // R9
			end else begin
				crc_mute_q <= crc_mute_q && alarm_q[BIT_LANE_CRC]; // R9
			end
		end
	end

	// DAC mute output
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dac_mute_o <= 1'b0;
		end else begin
			dac_mute_o <= link_mute_q || crc_mute_q
			           || (alarm_q[BIT_REF_MISALIGN] && !mute_src_q[BIT_REF_MISALIGN]); // R6
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bias outputs; sleep swaps in the sleep coarse value
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fine_bias_a_o   <= 6'h00;
			fine_bias_b_o   <= 6'h00;
			coarse_bias_a_o <= RST_COARSE_BIAS[3:0];
			coarse_bias_b_o <= RST_COARSE_BIAS[3:0];
		end else begin
			fine_bias_a_o   <= fine_a_q;
			fine_bias_b_o   <= fine_b_q;
			coarse_bias_a_o <= sleep_a_i ? coarse_a_q[7:4] : coarse_a_q[3:0]; // R17
			coarse_bias_b_o <= sleep_b_i ? coarse_b_q[7:4] : coarse_b_q[3:0]; // R17
		end
	end

	// Read data, registered; unmapped addresses read zero
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_ALARM_OUTPUT_MASK:  reg_rdata_o <= out_mask_q;
				OFS_DAC_MUTE_SRC_MASK:  reg_rdata_o <= mute_src_q;
				OFS_DAC_MUTE_RECOVERY:  reg_rdata_o <= recovery_q;
				OFS_FUSE_LOAD_STATUS:   reg_rdata_o <= {7'h00, fuse_done_o}; // R10
				OFS_FINE_BIAS_CHAN_A:   reg_rdata_o <= {2'h0, fine_a_q};
				OFS_FINE_BIAS_CHAN_B:   reg_rdata_o <= {2'h0, fine_b_q}; // R14
				OFS_COARSE_BIAS_CHAN_A: reg_rdata_o <= coarse_a_q;
				OFS_COARSE_BIAS_CHAN_B: reg_rdata_o <= coarse_b_q;
				default:                reg_rdata_o <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	fuse_bound_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R11
		!fuse_done_o |=> (fuse_cnt_q < 20'(FUSE_LOAD_BOUND_CYCLES)))
		else $error("fuse load exceeded bound");
	fuse_status_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R10
		fuse_done_o |-> fuse_state_q == FUSE_IDLE)
		else $error("fuse done before idle");
	loss_mask_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R1
		(out_mask_q == 8'h80 && !alarm_q[6] && !alarm_q[5] && !alarm_q[0]) |=> !alarm_o)
		else $error("masked link loss reached alarm");
	timeout_mask_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R2
		(alarm_q[6] && !out_mask_q[6]) |=> alarm_o)
		else $error("link timeout alarm not output");
	crc_alarm_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R3
		(alarm_q[5] && !out_mask_q[5]) |=> alarm_o)
		else $error("crc alarm not output");
	ref_alarm_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R4
		(alarm_q[0] && !out_mask_q[0]) |=> alarm_o)
		else $error("misalign alarm not output");
	ref_mute_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R6
		(alarm_q[0] && !mute_src_q[0]) |=> dac_mute_o)
		else $error("misalign did not mute");
	crc_mute_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R5
		(crc_fault_i && !mute_src_q[5]) |=> ##1 dac_mute_o)
		else $error("crc fault did not mute");
	// Recovery modes and alarm clearing; manual link-loss mode must not let go early
	link_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R7
		(link_mute_q && !recovery_q[BIT_LINK_LOSS] && alarm_q[BIT_LINK_LOSS]) |=> link_mute_q)
		else $error("manual link mute released early");
	mute_gate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R8
		mute_src_q[BIT_LANE_CRC] |=> !crc_mute_q)
		else $error("disabled crc source still mutes");
	crc_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R9
		(!mute_src_q[BIT_LANE_CRC] && recovery_q[BIT_LANE_CRC] && !crc_fault_i) |=> !crc_mute_q)
		else $error("crc auto unmute missed");
	loss_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R18
		(clear_bits[BIT_LINK_LOSS] && !alarm_set[BIT_LINK_LOSS]) |=> !alarm_q[BIT_LINK_LOSS])
		else $error("link loss alarm not cleared");
	loss_set_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R18
		(serial_link_enable_i && $fell(link_up_i) && link_up_q) |=> alarm_q[7])
		else $error("link loss alarm not set");
endmodule
`default_nettype wire

// *** include/alarm_bias_pkg.sv ***
// Register map, reset values and timing constants for the alarm, mute and bias register bank
package alarm_bias_pkg;
	localparam logic [11:0] OFS_ALARM_OUTPUT_MASK  = 12'h431;
	localparam logic [11:0] OFS_DAC_MUTE_SRC_MASK  = 12'h432;
	localparam logic [11:0] OFS_DAC_MUTE_RECOVERY  = 12'h433;
	localparam logic [11:0] OFS_FUSE_LOAD_STATUS   = 12'h600;
	localparam logic [11:0] OFS_FINE_BIAS_CHAN_A   = 12'h723;
	localparam logic [11:0] OFS_COARSE_BIAS_CHAN_A = 12'h724;
	localparam logic [11:0] OFS_FINE_BIAS_CHAN_B   = 12'h725;
	localparam logic [11:0] OFS_COARSE_BIAS_CHAN_B = 12'h726;
	// Alarm and mask bit positions
	localparam int BIT_LINK_LOSS    = 7;
	localparam int BIT_LINK_TIMEOUT = 6;
	localparam int BIT_LANE_CRC     = 5;
	localparam int BIT_REF_MISALIGN = 0;
	// Reset values
	localparam logic [7:0] RST_ALARM_OUTPUT_MASK = 8'h00;
	localparam logic [7:0] RST_DAC_MUTE_SRC_MASK = 8'h21;
	localparam logic [7:0] RST_DAC_MUTE_RECOVERY = 8'ha0;
	localparam logic [7:0] RST_COARSE_BIAS       = 8'h0f;
	localparam logic [5:0] RST_FINE_BIAS         = 6'h20;
	// Fuse auto-load bound: strictly fewer cycles than this
	localparam int FUSE_LOAD_BOUND_CYCLES = 523000;
	localparam int FUSE_LOAD_CYCLES       = FUSE_LOAD_BOUND_CYCLES - 1000;
	localparam int LINK_TIMER_W           = 16;
endpackage

// *** verification/test_alarm_mute_and_dac_bias_regs.sv ***
// Self-checking testbench for the alarm, mute and bias register bank
`timescale 1ns/1ps
`default_nettype none
module test_alarm_mute_and_dac_bias_regs;
	localparam int FC = 20;
	typedef struct {logic [11:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] b;} reg_row_t;
	typedef struct {int s; logic [7:0] mm; logic [7:0] rc; logic m; logic e1; logic e2;} mute_row_t;
	logic        clock_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic [7:0]  reg_rdata_o;
	logic        serial_link_enable_i = 1'b1;
	logic        link_up_i = 1'b1;
	logic [15:0] link_down_timer_i = 16'hffff;
	logic        crc_fault_i = 1'b0;
	logic        ref_misalign_i = 1'b0;
	logic        alarm_clear_i = 1'b0;
	logic [7:0]  alarm_clear_bits_i = 8'h00;
	logic        sleep_a_i = 1'b0;
	logic        sleep_b_i = 1'b0;
	logic [7:0]  alarm_status_o;
	logic        alarm_o;
	logic        dac_mute_o;
	logic        fuse_done_o;
	logic [5:0]  fine_bias_a_o;
	logic [5:0]  fine_bias_b_o;
	logic [3:0]  coarse_bias_a_o;
	logic [3:0]  coarse_bias_b_o;
	int          bad_count = 0;
	int          check_count = 0;
	int          n;
	logic [7:0]  v;
	reg_row_t    regs [9];
	mute_row_t   mutes [8];

	alarm_mute_and_dac_bias_regs #(.FUSE_CYCLES(FC)) alarm_mute_and_dac_bias_regs_i (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.serial_link_enable_i(serial_link_enable_i), .link_up_i(link_up_i),
		.link_down_timer_i(link_down_timer_i), .crc_fault_i(crc_fault_i),
		.ref_misalign_i(ref_misalign_i), .alarm_clear_i(alarm_clear_i),
		.alarm_clear_bits_i(alarm_clear_bits_i), .sleep_a_i(sleep_a_i), .sleep_b_i(sleep_b_i),
		.alarm_status_o(alarm_status_o), .alarm_o(alarm_o), .dac_mute_o(dac_mute_o),
		.fuse_done_o(fuse_done_o), .fine_bias_a_o(fine_bias_a_o), .fine_bias_b_o(fine_bias_b_o),
		.coarse_bias_a_o(coarse_bias_a_o), .coarse_bias_b_o(coarse_bias_b_o));

	// 50 MHz clock
	always #10 clock_i = ~clock_i;

	////////////////////////////////////////////////////////////////////////////
	// Tasks: every call starts and ends just after a falling edge
	task automatic step(input int c);
		repeat (c) @(negedge clock_i);
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Strobe drops one edge before return so back-to-back calls never double-drive
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		step(1);
		reg_wr_i = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		step(1);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
		step(1);
	endtask
	task automatic clr(input logic [7:0] b);
		alarm_clear_i = 1'b1;
		alarm_clear_bits_i = b;
		step(1);
		alarm_clear_i = 1'b0;
		step(1);
	endtask
	// Starts (on=1) or ends (on=0) the condition behind alarm bit s
	task automatic cause(input int s, input logic on);
		case (s)
			7: link_up_i = !on;
			5: crc_fault_i = on;
			0: if (on) begin
				ref_misalign_i = 1'b1;
				step(1);
				ref_misalign_i = 1'b0;
			end
			default: if (on) begin
				serial_link_enable_i = 1'b0;
				link_up_i = 1'b0;
				link_down_timer_i = 16'h0004;
				step(2);
				serial_link_enable_i = 1'b1;
				step(10);
			end else begin
				link_up_i = 1'b1;
				link_down_timer_i = 16'hffff;
			end
		endcase
	endtask
	task automatic wait_fuse();
		n = 0;
		while (fuse_done_o !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		chk("fuse done", {7'h00, fuse_done_o}, 8'h01);
		chk("fuse time", {7'h00, n < FC + 3}, 8'h01);
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clock_i);
		bad_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		regs = '{'{12'h431, 8'h00, 8'hff, 8'hff}, '{12'h432, 8'h21, 8'hff, 8'hff},
			'{12'h433, 8'ha0, 8'hff, 8'hff}, '{12'h600, 8'h01, 8'hff, 8'h01},
			'{12'h723, 8'h20, 8'hff, 8'h3f}, '{12'h724, 8'h0f, 8'ha5, 8'ha5},
			'{12'h725, 8'h20, 8'hff, 8'h3f}, '{12'h726, 8'h0f, 8'h5a, 8'h5a},
			'{12'h500, 8'h00, 8'hff, 8'h00}};
		mutes = '{'{7, 8'h00, 8'h20, 1, 1, 1}, '{7, 8'h00, 8'ha0, 1, 1, 0},
			'{5, 8'h00, 8'ha0, 1, 1, 0}, '{5, 8'h00, 8'h80, 1, 1, 1},
			'{5, 8'h20, 8'h80, 1, 0, 0}, '{0, 8'h00, 8'ha0, 1, 1, 1},
			'{0, 8'h01, 8'ha0, 1, 0, 0}, '{6, 8'h21, 8'ha0, 0, 0, 0}};
		step(5);
		arst_n_i = 1'b1;
		chk("load busy", {7'h00, fuse_done_o}, 8'h00);
		rd(12'h600, v);
		chk("status busy", v, 8'h00);
		// Early write must be dropped; the reset value is expected below
		wr(12'h724, 8'h33);
		wait_fuse();
		foreach (regs[i]) begin
			rd(regs[i].a, v);
			chk($sformatf("reset %h", regs[i].a), v, regs[i].r);
			wr(regs[i].a, regs[i].w);
			rd(regs[i].a, v);
			chk($sformatf("back %h", regs[i].a), v, regs[i].b);
		end
		// Bias outputs: sleep selects the upper nibble
		chk("fine a", {2'b00, fine_bias_a_o}, 8'h3f);
		chk("fine b", {2'b00, fine_bias_b_o}, 8'h3f);
		chk("coarse a", {4'h0, coarse_bias_a_o}, 8'h05);
		chk("coarse b", {4'h0, coarse_bias_b_o}, 8'h0a);
		sleep_a_i = 1'b1;
		sleep_b_i = 1'b1;
		step(3);
		chk("sleep a", {4'h0, coarse_bias_a_o}, 8'h0a);
		chk("sleep b", {4'h0, coarse_bias_b_o}, 8'h05);
		clr(8'hff);
		foreach (mutes[i]) begin
			wr(12'h432, mutes[i].mm);
			wr(12'h433, mutes[i].rc);
			wr(12'h431, 8'h00);
			cause(mutes[i].s, 1'b1);
			step(4);
			if (mutes[i].m) chk("mute on", {7'h00, dac_mute_o}, {7'h00, mutes[i].e1});
			chk("status", {7'h00, alarm_status_o[mutes[i].s]}, 8'h01);
			chk("alarm", {7'h00, alarm_o}, 8'h01);
			wr(12'h431, 8'h01 << mutes[i].s);
			step(3);
			chk("masked", {7'h00, alarm_o}, 8'h00);
			wr(12'h431, 8'h00);
			cause(mutes[i].s, 1'b0);
			step(4);
			if (mutes[i].m) chk("mute hold", {7'h00, dac_mute_o}, {7'h00, mutes[i].e2});
			clr(8'h01 << mutes[i].s);
			step(4);
			chk("mute off", {7'h00, dac_mute_o}, 8'h00);
			chk("cleared", alarm_status_o, 8'h00);
		end
		// Reset in mid-run restores defaults and restarts the fuse load
		arst_n_i = 1'b0;
		step(1);
		chk("rst coarse", {coarse_bias_a_o, coarse_bias_b_o}, 8'hff);
		chk("rst done", {7'h00, fuse_done_o}, 8'h00);
		arst_n_i = 1'b1;
		wait_fuse();
		rd(12'h724, v);
		chk("rst reg", v, 8'h0f);
		wrap_up();
	end
endmodule
`default_nettype wire
